/* gpt_pin_model.sv */
// Model of the external clock and gate pins feeding the timers.
`default_nettype none
module gpt_pin_model (
  input wire logic clk_i,
  output logic [4:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_o = 5'h00;
  // Rising edges counted: the pin rests low between pulses.
  task automatic pulses(input int slot, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      pin_o[slot] <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin_o[slot] <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask : pulses
  // Gate level: held until the next call.
  task automatic level(input int slot, input logic v);
    @(posedge clk_i);
    pin_o[slot] <= v;
  endtask : level
endmodule : gpt_pin_model
`default_nettype wire

/* gpt_pkg.sv */
// Shared constants, register map and control decode for the general-purpose timers.
`default_nettype none

package gpt_pkg;

  localparam int GPT_NUM = 5;
  localparam int GPT_ADDR_W = 8;
  localparam int GPT_DATA_W = 32;

  // Timer slots: 0 stand-alone, 1/2 first pair (lower/upper), 3/4 second pair.
  localparam int SINGLE_IDX = 0;
  localparam int PAIR_A_LO = 1;
  localparam int PAIR_A_HI = 2;
  localparam int PAIR_B_LO = 3;
  localparam int PAIR_B_HI = 4;

  // Byte address = {slot, field, 2'b00}; status sits after the last slot.
  localparam int SLOT_MSB = 6;
  localparam int SLOT_LSB = 4;
  localparam int FIELD_MSB = 3;
  localparam int FIELD_LSB = 2;
  localparam logic [1:0] FIELD_CTRL = 2'h0;
  localparam logic [1:0] FIELD_COUNT = 2'h1;
  localparam logic [1:0] FIELD_PERIOD = 2'h2;
  localparam logic [GPT_ADDR_W-1:0] STATUS_ADDR = 8'h50;

  // Control word bit positions.
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PS_MSB = 5;
  localparam int PS_LSB = 4;
  localparam int WIDE_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT = 1;

  // Implemented control bits per kind of slot; the rest are write-ignored, read zero.
  localparam logic [15:0] SINGLE_MASK = 16'hA076;
  localparam logic [15:0] LOWER_MASK = 16'hA07A;
  localparam logic [15:0] UPPER_MASK = 16'hA072;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

  // Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256.
  localparam logic [7:0] PS_TERM_1 = 8'h00;
  localparam logic [7:0] PS_TERM_8 = 8'h07;
  localparam logic [7:0] PS_TERM_64 = 8'h3F;
  localparam logic [7:0] PS_TERM_256 = 8'hFF;

  typedef struct packed {
    logic run;
    logic idle_halt;
    logic gated_accumulate_en;
    logic [1:0] prescale_select;
    logic pair_wide_mode;
    logic ext_clock_sync_sel;
    logic clock_source_sel;
  } gpt_ctrl_t;

  function automatic gpt_ctrl_t gpt_decode(input logic [15:0] w);
    gpt_ctrl_t c;
    c.run = w[RUN_BIT];
    c.idle_halt = w[IDLE_BIT];
    c.gated_accumulate_en = w[GATE_BIT];
    c.prescale_select = w[PS_MSB:PS_LSB];
    c.pair_wide_mode = w[WIDE_BIT];
    c.ext_clock_sync_sel = w[SYNC_BIT];
    c.clock_source_sel = w[SRC_BIT];
    return c;
  endfunction : gpt_decode

endpackage : gpt_pkg

`default_nettype wire

/* gpt_timers.sv */
// General-purpose timers: one stand-alone 16-bit timer and two pairable timer units behind APB.
`default_nettype none

module gpt_timers
  import gpt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [GPT_ADDR_W-1:0] paddr_i,
  input wire logic [GPT_DATA_W-1:0] pwdata_i,
  output logic [GPT_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic idle_i,
  input wire logic [GPT_NUM-1:0] ext_clock_pin_i,
  output logic [GPT_NUM-1:0] irq_flag_o,
  output logic adc_trigger_o
);

  logic [15:0] ctrl_reg [GPT_NUM];
  logic [15:0] count_reg [GPT_NUM];
  logic [15:0] period_reg [GPT_NUM];
  logic [7:0] ps_cnt_reg [GPT_NUM];
  logic [GPT_NUM-1:0] flag_reg;
  logic [GPT_NUM-1:0] sync1_reg;
  logic [GPT_NUM-1:0] sync2_reg;
  logic [GPT_NUM-1:0] sync3_reg;
  logic [GPT_NUM-1:0] pin_prev_reg;
  logic half_reg;
  logic adc_reg;
  logic [GPT_DATA_W-1:0] rdata_reg;
  logic err_reg;

  gpt_ctrl_t eff [GPT_NUM];
  logic [GPT_NUM-1:0] active;
  logic [GPT_NUM-1:0] in_tick;
  logic [GPT_NUM-1:0] tick;
  logic [GPT_NUM-1:0] gate_fall;
  logic [GPT_NUM-1:0] joined_hi;
  logic [GPT_NUM-1:0] match16;
  logic [GPT_NUM-1:0] match32;
  logic [GPT_NUM-1:0] set_evt;
  logic [GPT_NUM-1:0] wr_ctrl;
  logic [GPT_NUM-1:0] wr_count;
  logic [GPT_NUM-1:0] wr_period;
  logic wr_status;
  logic addr_ok;
  logic wr_en;

  function automatic logic is_lower(input int i);
    return (i == PAIR_A_LO) || (i == PAIR_B_LO);
  endfunction : is_lower
  function automatic logic is_upper(input int i);
    return (i == PAIR_A_HI) || (i == PAIR_B_HI);
  endfunction : is_upper
  function automatic logic [15:0] ctrl_mask(input int i);
    if (i == SINGLE_IDX)
    begin
      return SINGLE_MASK;
    end
    return is_lower(i) ? LOWER_MASK : UPPER_MASK;
  endfunction : ctrl_mask
  function automatic logic [2:0] slot_of(input logic [GPT_ADDR_W-1:0] a);
    return a[SLOT_MSB:SLOT_LSB];
  endfunction : slot_of
  function automatic logic [1:0] field_of(input logic [GPT_ADDR_W-1:0] a);
    return a[FIELD_MSB:FIELD_LSB];
  endfunction : field_of

  // Every register is a whole aligned word; anything else is an error.
  assign addr_ok = (paddr_i == STATUS_ADDR)
                   || ((paddr_i[1:0] == 2'b00) && (32'(slot_of(paddr_i)) < GPT_NUM) && (field_of(paddr_i) != 2'h3)
                       && (paddr_i[GPT_ADDR_W-1] == 1'b0));

  assign wr_en = psel_i & penable_i & pwrite_i & addr_ok;
  assign wr_status = wr_en & (paddr_i == STATUS_ADDR);

  always_comb
  begin
    for (int i = 0; i < GPT_NUM; i++)
    begin
      wr_ctrl[i] = wr_en & ~wr_status & (32'(slot_of(paddr_i)) == i) & (field_of(paddr_i) == FIELD_CTRL);
      wr_count[i] = wr_en & ~wr_status & (32'(slot_of(paddr_i)) == i) & (field_of(paddr_i) == FIELD_COUNT);
      wr_period[i] = wr_en & ~wr_status & (32'(slot_of(paddr_i)) == i) & (field_of(paddr_i) == FIELD_PERIOD);
    end
  end

  // Zero wait states: read data is captured in the setup cycle and shown in the access cycle.
  assign pready_o = 1'b1;
  assign prdata_o = rdata_reg;
  assign pslverr_o = err_reg & psel_i & penable_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      err_reg <= ~addr_ok;
      rdata_reg <= '0;
      if (!pwrite_i && addr_ok)
      begin
        if (paddr_i == STATUS_ADDR)
        begin
          rdata_reg <= {{(GPT_DATA_W-GPT_NUM){1'b0}}, flag_reg};
        end
        else
        begin
          case (field_of(paddr_i))
            FIELD_CTRL: rdata_reg <= {16'h0000, ctrl_reg[slot_of(paddr_i)] & ctrl_mask(32'(slot_of(paddr_i)))};
            FIELD_COUNT: rdata_reg <= {16'h0000, count_reg[slot_of(paddr_i)]};
            FIELD_PERIOD: rdata_reg <= {16'h0000, period_reg[slot_of(paddr_i)]};
            default: rdata_reg <= '0;
          endcase
        end
      end
    end
  end

  // Internal clock runs at half the system rate.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      half_reg <= 1'b0;
    end
    else
    begin
      half_reg <= ~half_reg;
    end
  end

  // Pin stages: a two-flop synchroniser, one more stage for edges, and a single-stage path for async counting.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= ext_clock_pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_prev_reg <= ext_clock_pin_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < GPT_NUM; g++)
    begin : g_slice
      localparam int SRC = (is_upper(g)) ? g - 1 : g;
      logic sync_edge;
      logic async_edge;
      logic ext_edge;
      logic gated;
      logic [7:0] term;

      assign joined_hi[g] = is_upper(g) && gpt_decode(ctrl_reg[SRC]).pair_wide_mode;
      assign eff[g] = joined_hi[g] ? gpt_decode(ctrl_reg[SRC] & LOWER_MASK) : gpt_decode(ctrl_reg[g] & ctrl_mask(g));

      assign sync_edge = sync2_reg[joined_hi[g] ? SRC : g] & ~sync3_reg[joined_hi[g] ? SRC : g];
      assign async_edge = ext_clock_pin_i[g] & ~pin_prev_reg[g];
      assign ext_edge = ((g == SINGLE_IDX) && !eff[g].ext_clock_sync_sel) ? async_edge : sync_edge;

      assign gated = eff[g].gated_accumulate_en & ~eff[g].clock_source_sel;
      assign active[g] = eff[g].run & ~(idle_i & eff[g].idle_halt);
      assign in_tick[g] = eff[g].clock_source_sel ? ext_edge
                          : (half_reg & (~gated | sync2_reg[joined_hi[g] ? SRC : g]));
      assign gate_fall[g] = active[g] & gated & sync3_reg[joined_hi[g] ? SRC : g] & ~sync2_reg[joined_hi[g] ? SRC : g];

      always_comb
      begin
        case (eff[g].prescale_select)
          2'b00: term = PS_TERM_1;
          2'b01: term = PS_TERM_8;
          2'b10: term = PS_TERM_64;
          default: term = PS_TERM_256;
        endcase
      end

      assign tick[g] = active[g] & in_tick[g] & (ps_cnt_reg[g] == term);

      always_ff @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          ps_cnt_reg[g] <= 8'h00;
        end
        else if (wr_ctrl[g] && gpt_decode(ctrl_reg[g]).run)
        begin
          ps_cnt_reg[g] <= 8'h00;
        end
        else if (active[g] && in_tick[g])
        begin
          ps_cnt_reg[g] <= (ps_cnt_reg[g] == term) ? 8'h00 : ps_cnt_reg[g] + 8'h01;
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          ctrl_reg[g] <= CTRL_RST;
          period_reg[g] <= PERIOD_RST;
        end
        else
        begin
          if (wr_ctrl[g])
          begin
            ctrl_reg[g] <= pwdata_i[15:0] & ctrl_mask(g);
          end
          if (wr_period[g])
          begin
            period_reg[g] <= pwdata_i[15:0];
          end
        end
      end
    end
  endgenerate

  // Match detection and flag events per slot.
  always_comb
  begin
    match32 = '0;
    set_evt = '0;
    for (int i = 0; i < GPT_NUM; i++)
    begin
      match16[i] = (count_reg[i] == period_reg[i]);
      if (is_lower(i))
      begin
        match32[i] = ({count_reg[i+1], count_reg[i]} == {period_reg[i+1], period_reg[i]});
      end
      if (is_lower(i) && joined_hi[i+1])
      begin
        set_evt[i+1] = (tick[i] & match32[i]) | gate_fall[i];
      end
      else if (!joined_hi[i])
      begin
        set_evt[i] = (tick[i] & match16[i]) | gate_fall[i];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      count_reg <= '{default: COUNT_RST};
    end
    else
    begin
      for (int i = 0; i < GPT_NUM; i++)
      begin
        if (wr_count[i])
        begin
          count_reg[i] <= pwdata_i[15:0];
        end
        else if (joined_hi[i])
        begin
          if (tick[i-1])
          begin
            count_reg[i] <= match32[i-1] ? COUNT_RST
                            : count_reg[i] + 16'((count_reg[i-1] == COUNT_ALL_ONES) ? 1 : 0);
          end
        end
        else if (is_lower(i) && joined_hi[i+1])
        begin
          if (tick[i])
          begin
            count_reg[i] <= match32[i] ? COUNT_RST : count_reg[i] + 16'h0001;
          end
        end
        else if (tick[i])
        begin
          count_reg[i] <= match16[i] ? COUNT_RST : count_reg[i] + 16'h0001;
        end
      end
    end
  end

  // Flags are cleared by writing ones to status; a set in the same cycle wins.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      flag_reg <= '0;
    end
    else
    begin
      flag_reg <= (flag_reg & ~(wr_status ? pwdata_i[GPT_NUM-1:0] : '0)) | set_evt;
    end
  end

  assign irq_flag_o = flag_reg;

  // Converter trigger is a one-cycle pulse on a first-pair upper (or joined 32-bit) period match only.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      adc_reg <= 1'b0;
    end
    else
    begin
      adc_reg <= joined_hi[PAIR_A_HI] ? (tick[PAIR_A_LO] & match32[PAIR_A_LO])
                 : (tick[PAIR_A_HI] & match16[PAIR_A_HI]);
    end
  end

  assign adc_trigger_o = adc_reg;

endmodule : gpt_timers

`default_nettype wire

/* gpt_timers_properties.sv */
// Port-level checks for the general-purpose timers, bound to the top module.
`default_nettype none
module gpt_checker
  import gpt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [GPT_ADDR_W-1:0] paddr_i,
  input wire logic [GPT_DATA_W-1:0] pwdata_i,
  input wire logic [GPT_DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic idle_i,
  input wire logic [GPT_NUM-1:0] ext_clock_pin_i,
  input wire logic [GPT_NUM-1:0] irq_flag_o,
  input wire logic adc_trigger_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic acc;
  logic mapped;
  logic [4:0] clr;
  assign acc = psel_i && penable_i;
  assign mapped = (paddr_i == STATUS_ADDR) || (paddr_i[1:0] == 2'h0 && paddr_i[7:4] < 4'h5 && paddr_i[3:2] != 2'h3);
  // Only a status write of one may take a flag down; set wins over clear.
  assign clr = (acc && pwrite_i && paddr_i == STATUS_ADDR) ? pwdata_i[4:0] : 5'h00;
  err_unmapped_a: assert property (acc |-> pslverr_o == !mapped)
    else $error("slave error does not follow the address map");
  err_access_a: assert property (pslverr_o |-> acc)
    else $error("slave error outside an access phase");
  rd_unmapped_a: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  rd_hold_a: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
    else $error("read data changed outside a setup cycle");
  rd_upper_a: assert property (acc |-> prdata_o[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  adc_pulse_a: assert property (adc_trigger_o |=> !adc_trigger_o)
    else $error("converter trigger longer than one cycle");
  adc_flag_a: assert property (adc_trigger_o |-> irq_flag_o[PAIR_A_HI])
    else $error("converter trigger without first pair upper flag");
  flag_sticky_a: assert property (((~irq_flag_o & $past(irq_flag_o)) & ~$past(clr)) == 5'h00)
    else $error("flag fell without a clearing write");
  flag_reset_a: assert property ($rose(rst_b_i) |-> irq_flag_o == 5'h00 && !adc_trigger_o)
    else $error("flags or trigger active after reset");
endmodule : gpt_checker

bind gpt_timers gpt_checker u_gpt_checker (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .idle_i, .ext_clock_pin_i, .irq_flag_o, .adc_trigger_o);
`default_nettype wire

/* gpt_timers_tb_top.sv */
// Self-checking bench for the general-purpose timers.
`default_nettype none
module gpt_timers_tb_top
  import gpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_b_i, psel, penable, pwrite, pready, pslverr, idle, adc, err_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, keep;
  logic [4:0] pins, irq;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int per[4] = '{4, 32, 256, 1024};

  always #2.5 clk_i = ~clk_i;

  gpt_timers u_gpt_timers (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .idle_i(idle), .ext_clock_pin_i(pins), .irq_flag_o(irq), .adc_trigger_o(adc));
  gpt_pin_model u_gpt_pin_model (.clk_i(clk_i), .pin_o(pins));

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] ra(input int s, input logic [1:0] f);
    return {1'b0, s[2:0], f, 2'b00};
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic wait_irq(input int s, input int lim, input logic exp);
    n = 0;
    while (irq[s] !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    check(irq[s], exp);
  endtask : wait_irq

  task automatic wait_adc(input int lim);
    n = 0;
    while (adc !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_adc

  task automatic setup(input int s, input logic [31:0] prd, input logic [31:0] ctl);
    wr(ra(s, FIELD_COUNT), 32'h0000_0000);
    wr(ra(s, FIELD_PERIOD), prd);
    // Run bit last: control is the final write.
    wr(ra(s, FIELD_CTRL), ctl);
  endtask : setup

  task automatic stop_clear(input int s);
    wr(ra(s, FIELD_CTRL), 32'h0000_0000);
    wr(STATUS_ADDR, 32'h0000_001F);
    // The bench reads outputs before the edge updates them, so let the clear land first.
    @(posedge clk_i);
    check(irq, 5'h00);
  endtask : stop_clear

  task automatic t_regs;
    apb(1'b0, ra(0, FIELD_PERIOD), 32'h0000_0000);
    check(rd_v, 32'h0000_FFFF);
    for (int s = 0; s < 5; s++)
    begin
      apb(1'b0, ra(s, FIELD_CTRL), 32'h0000_0000);
      check(rd_v, 32'h0000_0000);
      wr(ra(s, FIELD_CTRL), 32'h0000_5FFF);
      apb(1'b0, ra(s, FIELD_CTRL), 32'h0000_0000);
      check(rd_v[15:0], s == 0 ? SINGLE_MASK & 16'h5FFF : s % 2 ? LOWER_MASK & 16'h5FFF : UPPER_MASK & 16'h5FFF);
      wr(ra(s, FIELD_CTRL), 32'h0000_0000);
    end
    apb(1'b0, 8'h60, 32'h0000_0000);
    check({rd_v[30:0], err_v}, 32'h0000_0001);
    apb(1'b1, ra(0, 2'h3), 32'h0000_1234);
    check(err_v, 1'b1);
  endtask : t_regs

  task automatic t_internal;
    setup(0, 32'h0000_0002, 32'h0000_8000);
    wait_irq(0, 3, 1'b0);
    wait_irq(0, 10, 1'b1);
    wr(ra(0, FIELD_CTRL), 32'h0000_0000);
    apb(1'b0, ra(0, FIELD_COUNT), 32'h0000_0000);
    keep = rd_v;
    repeat (6) @(posedge clk_i);
    apb(1'b0, ra(0, FIELD_COUNT), 32'h0000_0000);
    check(rd_v, keep);
    stop_clear(0);
  endtask : t_internal

  task automatic t_prescale;
    for (int c = 0; c < 4; c++)
    begin
      setup(2, 32'h0000_0001, 32'h0000_8000 | (c << 4));
      wait_adc(1100);
      @(posedge clk_i);
      wait_adc(1100);
      check(n + 1, per[c]);
      stop_clear(2);
    end
  endtask : t_prescale

  // A control rewrite mid-count must restart the 1:8 prescaler, pushing the next tick out.
  task automatic t_ps_clear;
    setup(2, 32'h0000_0000, 32'h0000_8010);
    wait_adc(40);
    repeat (4) @(posedge clk_i);
    wr(ra(2, FIELD_CTRL), 32'h0000_8010);
    wait_adc(40);
    check(n > 12, 1'b1);
    stop_clear(2);
  endtask : t_ps_clear

  task automatic t_wide;
    wr(ra(1, FIELD_CTRL), 32'h0000_0008);
    wr(ra(2, FIELD_CTRL), 32'h0000_8030);
    wr(ra(2, FIELD_COUNT), 32'h0000_0000);
    wr(ra(1, FIELD_PERIOD), 32'h0000_0000);
    wr(ra(2, FIELD_PERIOD), 32'h0000_0001);
    wr(ra(1, FIELD_COUNT), 32'h0000_FFFE);
    wr(ra(1, FIELD_CTRL), 32'h0000_8008);
    wait_adc(12);
    check(adc, 1'b1);
    check(irq[2:1], 2'b10);
    wr(ra(2, FIELD_CTRL), 32'h0000_0000);
    stop_clear(1);
  endtask : t_wide

  task automatic t_ext;
    for (int i = 0; i < 3; i++)
    begin
      setup(i == 2 ? 3 : 0, 32'h0000_0002, 32'h0000_8002 | ((i == 1) << 2));
      u_gpt_pin_model.pulses(i == 2 ? 3 : 0, 2);
      wait_irq(i == 2 ? 3 : 0, 6, 1'b0);
      u_gpt_pin_model.pulses(i == 2 ? 3 : 0, 1);
      wait_irq(i == 2 ? 3 : 0, 8, 1'b1);
      stop_clear(i == 2 ? 3 : 0);
    end
  endtask : t_ext

  task automatic t_gate;
    setup(0, 32'h0000_FFFF, 32'h0000_8040);
    u_gpt_pin_model.level(0, 1'b1);
    wait_irq(0, 20, 1'b0);
    u_gpt_pin_model.level(0, 1'b0);
    wait_irq(0, 8, 1'b1);
    stop_clear(0);
    setup(0, 32'h0000_FFFF, 32'h0000_8042);
    u_gpt_pin_model.pulses(0, 1);
    wait_irq(0, 10, 1'b0);
    stop_clear(0);
  endtask : t_gate

  task automatic t_idle;
    idle <= 1'b1;
    setup(0, 32'h0000_0002, 32'h0000_A000);
    wait_irq(0, 30, 1'b0);
    apb(1'b0, ra(0, FIELD_COUNT), 32'h0000_0000);
    check(rd_v, 32'h0000_0000);
    idle <= 1'b0;
    wait_irq(0, 12, 1'b1);
    stop_clear(0);
    idle <= 1'b1;
    setup(0, 32'h0000_0002, 32'h0000_8000);
    wait_irq(0, 12, 1'b1);
    idle <= 1'b0;
    stop_clear(0);
  endtask : t_idle

  initial
  begin
    rst_b_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    idle = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_internal();
    t_prescale();
    t_ps_clear();
    t_wide();
    t_ext();
    t_gate();
    t_idle();
    conclude();
  end
endmodule : gpt_timers_tb_top
`default_nettype wire
